// >>> rtl/msem_regs.svh
`ifndef MSEM_REGS_SVH
`define MSEM_REGS_SVH

`define MSEM_FC_RD_COILS      8'h01
`define MSEM_FC_RD_REGS       8'h03
`define MSEM_FC_WR_COIL       8'h05
`define MSEM_FC_WR_REG        8'h06
`define MSEM_FC_WR_MULTI      8'h10
`define MSEM_FC_ERR_BIT       8'h80

`define MSEM_EX_CMD           8'h51
`define MSEM_EX_RUN           8'h52
`define MSEM_EX_PASSWORD      8'h53
`define MSEM_EX_DATA          8'h54
`define MSEM_EX_OTHER         8'h57
`define MSEM_EX_EDITOR        8'h58

`define MSEM_ADDR_BCAST       8'h00
`define MSEM_ADDR_MAX         8'h63
`define MSEM_MAX_BYTES        8'd128

`define MSEM_CWL_LO           16'h0000
`define MSEM_CWL_HI           16'h0016
`define MSEM_CCL_LO           16'h0100
`define MSEM_CCL_HI           16'h012f
`define MSEM_CVL_LO           16'h0200
`define MSEM_CVL_HI           16'h0237
`define MSEM_CVL_EXTRA        16'h0260
`define MSEM_UCT_LO           16'h0300
`define MSEM_UCT_HI           16'h033b
`define MSEM_PVL_LO           16'h0400
`define MSEM_PVL_HI           16'h043e
`define MSEM_CBL_LO           16'h0500
`define MSEM_CBL_HI           16'h05ff
`define MSEM_CWN_LO           16'h0600
`define MSEM_CWN_HI           16'h0630
`define MSEM_CCN_LO           16'h0700
`define MSEM_CCN_HI           16'h072f
`define MSEM_CVN_LO           16'h0800
`define MSEM_CVN_HI           16'h11ef
`define MSEM_PVN_LO           16'h1200
`define MSEM_PVN_HI           16'h2703
`define MSEM_CBN_LO           16'h2b00
`define MSEM_CBN_HI           16'h2e0f

`endif

// >>> rtl/msem_pkg.sv
package msem_pkg;

    // region classes for the decoded start address
    typedef enum logic [7:0] {
        RG_NONE  = 8'b0000_0001,
        RG_WORD  = 8'b0000_0010,
        RG_CMD   = 8'b0000_0100,
        RG_CUR   = 8'b0000_1000,
        RG_CHAR  = 8'b0001_0000,
        RG_PRE_L = 8'b0010_0000,
        RG_PRE_N = 8'b0100_0000,
        RG_BIT   = 8'b1000_0000
    } msem_region_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EVAL = 3'b010,
        ST_DONE = 3'b100
    } msem_state_e;

    typedef struct packed {
        logic [7:0]  slave;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] count;
        logic [7:0]  nbytes;
        logic        parity_err;
        logic        data_bad;
    } msem_req_s;

    typedef struct packed {
        logic       exc;
        logic       bcast;
        logic       silent;
        logic [7:0] func;
        logic [7:0] code;
    } msem_rsp_s;

endpackage : msem_pkg

// >>> rtl/msem_region_dec.sv
`timescale 1ns/10ps
`include "msem_regs.svh"
module msem_region_dec
    import msem_pkg::*;
(
    // address in
    input  wire logic [15:0] addr,
    // class out
    output msem_region_e     region
);
    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    always_comb begin
        region = RG_NONE;
        if (in_rng(addr, `MSEM_CWL_LO, `MSEM_CWL_HI) || in_rng(addr, `MSEM_CWN_LO, `MSEM_CWN_HI))
            region = RG_WORD;
        else if (in_rng(addr, `MSEM_CCL_LO, `MSEM_CCL_HI)
                 || in_rng(addr, `MSEM_CCN_LO, `MSEM_CCN_HI))
            region = RG_CMD;
        else if (in_rng(addr, `MSEM_CVL_LO, `MSEM_CVL_HI) || addr == `MSEM_CVL_EXTRA
                 || in_rng(addr, `MSEM_CVN_LO, `MSEM_CVN_HI))
            region = RG_CUR;
        else if (in_rng(addr, `MSEM_UCT_LO, `MSEM_UCT_HI))
            region = RG_CHAR;
        else if (in_rng(addr, `MSEM_PVL_LO, `MSEM_PVL_HI))
            region = RG_PRE_L;
        else if (in_rng(addr, `MSEM_PVN_LO, `MSEM_PVN_HI))
            region = RG_PRE_N;
        else if (in_rng(addr, `MSEM_CBL_LO, `MSEM_CBL_HI)
                 || in_rng(addr, `MSEM_CBN_LO, `MSEM_CBN_HI))
            region = RG_BIT;
    end
endmodule : msem_region_dec

// >>> rtl/msem_checker.sv
`timescale 1ns/10ps
`include "msem_regs.svh"
module msem_checker
    import msem_pkg::*;
(
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // station setup
    input  wire logic [7:0] STATION_ID,
    // controller state
    input  wire logic       CTRL_RUNNING,
    input  wire logic       CTRL_LOCKED,
    input  wire logic       CTRL_FAULT,
    input  wire logic       EDITOR_CLASH,
    // request
    input  wire logic       REQ_VALID,
    input  wire msem_req_s  REQ,
    output logic            REQ_READY,
    // verdict
    output logic            RSP_VALID,
    output msem_rsp_s       RSP,
    output logic [7:0]      LAST_CODE
);
    msem_state_e  state_q, state_d;
    msem_req_s    req_q, req_d;
    msem_rsp_s    rsp_q, rsp_d;
    logic [7:0]   last_q, last_d;
    msem_region_e region;
    logic         fc_ok, is_write, run_block, bcast, mine, too_long;

    msem_region_dec u_dec (
        .addr   (req_q.addr),
        .region (region)
    );

    // function code permitted in the region
    always_comb begin
        fc_ok = 1'b0;
        unique case (region)
            RG_WORD, RG_CMD, RG_PRE_N:
                fc_ok = req_q.func == `MSEM_FC_RD_REGS || req_q.func == `MSEM_FC_WR_REG
                        || req_q.func == `MSEM_FC_WR_MULTI;
            RG_CUR:
                fc_ok = req_q.func == `MSEM_FC_RD_REGS;
            RG_CHAR, RG_PRE_L:
                fc_ok = req_q.func == `MSEM_FC_RD_REGS
                        || req_q.func == `MSEM_FC_WR_MULTI;
            RG_BIT:
                fc_ok = req_q.func == `MSEM_FC_RD_COILS
                        || req_q.func == `MSEM_FC_WR_COIL;
            RG_NONE:
                fc_ok = 1'b0;
            default:
                fc_ok = 1'b0;
        endcase
    end

    assign is_write  = req_q.func == `MSEM_FC_WR_COIL || req_q.func == `MSEM_FC_WR_REG
                       || req_q.func == `MSEM_FC_WR_MULTI;
    // edits to character and RG_PRE_L preset areas are refused while running (RG_PRE_N is not)
    assign run_block = CTRL_RUNNING && is_write
                       && (region == RG_CHAR || region == RG_PRE_L);
    assign bcast     = req_q.slave == `MSEM_ADDR_BCAST;
    assign mine      = bcast || (req_q.slave == STATION_ID
                       && req_q.slave <= `MSEM_ADDR_MAX);
    assign too_long  = req_q.nbytes > `MSEM_MAX_BYTES;

    always_comb begin
        state_d = state_q;
        req_d   = req_q;
        rsp_d   = rsp_q;
        last_d  = last_q;
        unique case (state_q)
            ST_IDLE: begin
                if (REQ_VALID) begin
                    req_d   = REQ;
                    state_d = ST_EVAL;
                end
            end
            ST_EVAL: begin
                rsp_d.func   = req_q.func;
                rsp_d.code   = 8'h00;
                rsp_d.exc    = 1'b1;
                rsp_d.bcast  = bcast;
                rsp_d.silent = !mine || bcast; // broadcasts get no reply
                // priority: frame faults, then clash/lock/run state, then content, then controller fault
                if (req_q.parity_err || !fc_ok || too_long)
                    rsp_d.code = `MSEM_EX_CMD;
                else if (EDITOR_CLASH)
                    rsp_d.code = `MSEM_EX_EDITOR;
                else if (CTRL_LOCKED)
                    rsp_d.code = `MSEM_EX_PASSWORD;
                else if (run_block)
                    rsp_d.code = `MSEM_EX_RUN;
                else if (req_q.data_bad)
                    rsp_d.code = `MSEM_EX_DATA;
                else if (CTRL_FAULT)
                    rsp_d.code = `MSEM_EX_OTHER;
                else
                    rsp_d.exc = 1'b0;
                if (rsp_d.exc) begin
                    rsp_d.func = req_q.func | `MSEM_FC_ERR_BIT;
                    if (mine)
                        last_d = rsp_d.code;
                end
                state_d = ST_DONE;
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_IDLE;
            req_q   <= '0;
            rsp_q   <= '0;
            last_q  <= 8'h00;
        end else begin
            state_q <= state_d;
            req_q   <= req_d;
            rsp_q   <= rsp_d;
            last_q  <= last_d;
        end
    end

    assign REQ_READY = state_q == ST_IDLE;
    assign RSP_VALID = state_q == ST_DONE;
    assign RSP       = rsp_q;
    assign LAST_CODE = last_q;
endmodule : msem_checker

// >>> verif/msem_chk.sv
`timescale 1ns/10ps
module msem_chk
    import msem_pkg::*;
(
    // clock, reset and station id
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [7:0] STATION_ID,
    // request and verdict
    input wire logic       REQ_VALID,
    input wire msem_req_s  REQ,
    input wire logic       REQ_READY,
    input wire logic       RSP_VALID,
    input wire msem_rsp_s  RSP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    wire tk = REQ_VALID && REQ_READY;
    property p_lat; tk |=> !REQ_READY ##1 (RSP_VALID && !REQ_READY); endproperty
    a_lat: assert property (p_lat) else $error("verdict timing wrong");
    property p_one; RSP_VALID |=> !RSP_VALID; endproperty
    a_one: assert property (p_one) else $error("verdict longer than one cycle");
    property p_bit; RSP_VALID && RSP.exc |-> RSP.func == {1'b1, $past(REQ.func[6:0], 2)}; endproperty
    a_bit: assert property (p_bit) else $error("exception function wrong");
    property p_par; tk && REQ.parity_err |-> ##2 RSP.exc && RSP.code == 8'h51; endproperty
    a_par: assert property (p_par) else $error("parity fault not 51");
    property p_len; tk && REQ.nbytes > 8'd128 |-> ##2 RSP.code == 8'h51; endproperty
    a_len: assert property (p_len) else $error("long transfer not refused");
    property p_cur;
        tk && REQ.func == 8'h06 && REQ.addr inside {[16'h0800:16'h11ef]} |-> ##2 RSP.exc;
    endproperty
    a_cur: assert property (p_cur) else $error("write to current value taken");
    property p_pre;
        tk && REQ.func == 8'h06 && REQ.addr inside {[16'h0400:16'h043e]} |-> ##2 RSP.code == 8'h51;
    endproperty
    a_pre: assert property (p_pre) else $error("single write to preset taken");
    property p_bc; tk && REQ.slave == 8'h00 |-> ##2 RSP.bcast; endproperty
    a_bc: assert property (p_bc) else $error("broadcast not flagged");
    property p_sil; tk && REQ.slave != 8'h00 && REQ.slave != STATION_ID |-> ##2 RSP.silent; endproperty
    a_sil: assert property (p_sil) else $error("foreign station answered");
    property p_cod;
        RSP_VALID && RSP.exc |-> RSP.code inside {8'h51, 8'h52, 8'h53, 8'h54, 8'h57, 8'h58};
    endproperty
    a_cod: assert property (p_cod) else $error("unknown exception code");
endmodule : msem_chk

// >>> verif/msem_host.sv
`timescale 1ns/10ps
module msem_host
    import msem_pkg::*;
(
    // clock and command
    input wire logic      CLK,
    input wire logic      go,
    input wire msem_req_s cmd,
    // request side
    input wire logic      REQ_READY,
    output logic          REQ_VALID,
    output msem_req_s     REQ
);
    initial begin
        REQ_VALID = 1'b0;
        REQ       = '0;
    end
    always @(posedge CLK) begin
        if (REQ_VALID && REQ_READY) begin
            REQ_VALID <= 1'b0;
            // released lines must not keep the old frame
            REQ       <= ~REQ;
        end else if (go && !REQ_VALID) begin
            REQ_VALID <= 1'b1;
            REQ       <= cmd;
        end
    end
endmodule : msem_host

// >>> verif/tb_msem_checker.sv
`timescale 1ns/10ps
module tb_msem_checker
    import msem_pkg::*;
;
    logic       CLK = 1'b0;
    logic       RST = 1'b1;
    logic       go  = 1'b0;
    logic [3:0] ctl = 4'h0;
    logic [3:0] ctl_n = 4'h0;
    logic [7:0] sid   = 8'h05;
    msem_req_s  cmd = '0;
    msem_req_s  nxt = '{8'h05, 8'h03, 16'h0000, 16'h0001, 8'h04, 1'b0, 1'b0};
    logic       REQ_VALID, REQ_READY, RSP_VALID;
    msem_req_s  REQ;
    msem_rsp_s  RSP;
    logic [7:0] LAST_CODE;
    int         errors = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    logic [7:0]  tf [19] = '{8'h03, 8'h06, 8'h10, 8'h03, 8'h06, 8'h06, 8'h10, 8'h06, 8'h06, 8'h05,
                             8'h03, 8'h01, 8'h06, 8'h10, 8'h01, 8'h03, 8'h03, 8'h06, 8'h08};
    logic [15:0] ta [19] = '{16'h0200, 16'h0200, 16'h0260, 16'h0800, 16'h11ef, 16'h0400, 16'h043e,
                             16'h1200, 16'h2703, 16'h0500, 16'h0500, 16'h2b00, 16'h0000, 16'h0700,
                             16'h0100, 16'h0238, 16'h0300, 16'h0300, 16'h0000};
    logic [7:0]  te [19] = '{8'h00, 8'h51, 8'h51, 8'h00, 8'h51, 8'h51, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h51, 8'h00, 8'h00, 8'h00, 8'h51, 8'h51, 8'h00, 8'h51, 8'h51};
    logic [7:0]  tc [4] = '{8'h52, 8'h53, 8'h57, 8'h58};
    msem_host host_u (.CLK(CLK), .go(go), .cmd(cmd), .REQ_READY(REQ_READY),
                      .REQ_VALID(REQ_VALID), .REQ(REQ));
    msem_checker dut_u (.CLK(CLK), .RST(RST), .STATION_ID(sid), .CTRL_RUNNING(ctl[3]),
        .CTRL_LOCKED(ctl[2]), .CTRL_FAULT(ctl[1]), .EDITOR_CLASH(ctl[0]), .REQ_VALID(REQ_VALID),
        .REQ(REQ), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP(RSP), .LAST_CODE(LAST_CODE));
    initial forever #12.5 CLK = ~CLK;
    task automatic stop_test();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            stop_test();
        end
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [7:0] ex);
        int n;
        nxt.func = f;
        nxt.addr = a;
        @(posedge CLK);
        cmd <= nxt;
        ctl <= ctl_n;
        go  <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        n = 0;
        @(negedge CLK);
        while (RSP_VALID !== 1'b1 && n < 8) begin
            @(negedge CLK);
            n++;
        end
        cmp({7'h0, RSP_VALID}, 8'h01);
        cmp(RSP.func, ex != 8'h00 ? (f | 8'h80) : f);
        cmp({7'h0, RSP.exc}, {7'h0, ex != 8'h00});
        if (ex != 8'h00) cmp(RSP.code, ex);
    endtask : send
    initial begin
        repeat (2) @(posedge CLK);
        cmp(LAST_CODE, 8'h00);
        cmp({7'h0, REQ_READY}, 8'h01);
        RST <= 1'b0;
        for (int i = 0; i < 19; i++) send(tf[i], ta[i], te[i]);
        nxt.parity_err = 1'b1;
        send(8'h03, 16'h0200, 8'h51);
        nxt.parity_err = 1'b0;
        nxt.nbytes = 8'd129;
        send(8'h03, 16'h0200, 8'h51);
        nxt.nbytes = 8'd128;
        send(8'h03, 16'h0200, 8'h00);
        nxt.data_bad = 1'b1;
        send(8'h10, 16'h1200, 8'h54);
        nxt.data_bad = 1'b0;
        for (int i = 0; i < 4; i++) begin
            ctl_n = 4'h8 >> i;
            send(8'h10, 16'h0400, tc[i]);
        end
        // clash outranks the lock
        ctl_n = 4'h5;
        send(8'h10, 16'h0400, 8'h58);
        cmp(LAST_CODE, 8'h58);
        ctl_n = 4'h0;
        nxt.slave = 8'h00;
        send(8'h06, 16'h0200, 8'h51);
        cmp({7'h0, RSP.bcast}, 8'h01);
        ctl_n = 4'h1;
        nxt.slave = 8'h07;
        send(8'h03, 16'h0300, 8'h58);
        cmp({7'h0, RSP.silent}, 8'h01);
        cmp(LAST_CODE, 8'h51);
        // same frame is answered once the station id matches
        @(posedge CLK);
        sid <= 8'h07;
        send(8'h03, 16'h0300, 8'h58);
        cmp({7'h0, RSP.silent}, 8'h00);
        cmp(LAST_CODE, 8'h58);
        // ids above the station range never answer
        @(posedge CLK);
        sid <= 8'h64;
        nxt.slave = 8'h64;
        ctl_n = 4'h2;
        send(8'h03, 16'h0300, 8'h57);
        cmp({7'h0, RSP.silent}, 8'h01);
        cmp(LAST_CODE, 8'h58);
        // reset in mid-run clears the remembered code
        @(posedge CLK);
        RST <= 1'b1;
        sid <= 8'h05;
        @(posedge CLK);
        RST <= 1'b0;
        @(negedge CLK);
        cmp(LAST_CODE, 8'h00);
        cmp({7'h0, REQ_READY}, 8'h01);
        ctl_n = 4'h0;
        nxt.slave = 8'h05;
        send(8'h10, 16'h0630, 8'h00);
        cmp(LAST_CODE, 8'h00);
        stop_test();
    end
endmodule : tb_msem_checker
bind msem_checker msem_chk chk_u (.CLK(CLK), .RST(RST), .STATION_ID(STATION_ID),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP(RSP));
